/* hdl/punch_cycle_ctrl.sv */
// punch cycle control: digit timing, hole checks, repeat, pilot selectors
// assumes AXI4-Lite master on aclk; brush and error inputs synchronous
`timescale 1ns/1ps
module punch_cycle_ctrl (
   input  wire logic           aclk,           // 125 MHz clock
   input  wire logic           aresetn,        // sync reset, active low
   input  wire logic [7:0]     awaddr,         // write address
   input  wire logic           awvalid,        // write address valid
   output logic                awready,        // write address ready
   input  wire logic [31:0]    wdata,          // write data
   input  wire logic [3:0]     wstrb,          // write byte lanes
   input  wire logic           wvalid,         // write data valid
   output logic                wready,         // write data ready
   output logic [1:0]          bresp,          // write response
   output logic                bvalid,         // write response valid
   input  wire logic           bready,         // write response ready
   input  wire logic [7:0]     araddr,         // read address
   input  wire logic           arvalid,        // read address valid
   output logic                arready,        // read address ready
   output logic [31:0]         rdata,          // read data
   output logic [1:0]          rresp,          // read response
   output logic                rvalid,         // read data valid
   input  wire logic           rready,         // read data ready
   input  wire punch_pkg::brush_t brush,       // read-back brush events
   input  wire logic           output_error,   // output error pulse
   output logic                machine_halt,   // machine stopped
   output logic                check_light,    // check indicator
   output logic                card_offset,    // offset card pulse
   output logic                punching,       // digit times running
   output logic [3:0]          digit_slot,     // current digit slot
   output logic                half_after_zero,// 0.5 impulse
   output logic                repeat_out,     // repeat out pulse
   output logic                combined_entry, // first hole exit pulse
   output logic [9:0]          selector_xfer,  // pilot selector state
   output logic [9:0]          couple_out      // couple exit pulses
);
   punch_pkg::ctrl_t      ctrl;
   logic [31:0]           chain;
   punch_pkg::cyc_state_t state;
   punch_pkg::cyc_state_t next_state;
   logic [7:0]            sub;
   logic [3:0]            slot;
   logic                  punch_req;
   logic                  rep_req;
   logic                  rep_pend;
   logic                  dp_err;
   logic                  bc_err;
   logic                  out_err;
   logic [1:0]            hole_cnt;
   logic                  first_seen;

   // byte-lane mask from the write strobes
   wire [31:0] lane = {{8{wstrb[3]}}, {8{wstrb[2]}},
                       {8{wstrb[1]}}, {8{wstrb[0]}}};
   wire [31:0] wmask = wdata & lane;

   // write channel: both address and data must be present
   wire wr_go   = awvalid & wvalid & ~awready & ~bvalid;
   wire wr_ctrl = wr_go & (awaddr == punch_pkg::ADDR_CTRL);
   wire wr_cmd  = wr_go & (awaddr == punch_pkg::ADDR_CMD);
   wire wr_pp   = wr_go & (awaddr == punch_pkg::ADDR_PICK_P);
   wire wr_pd   = wr_go & (awaddr == punch_pkg::ADDR_PICK_D);
   wire wr_chn  = wr_go & (awaddr == punch_pkg::ADDR_CHAIN);
   wire wr_ok   = wr_ctrl | wr_cmd | wr_pp | wr_pd | wr_chn;

   // command pulses
   wire cmd_punch   = wr_cmd & wmask[punch_pkg::CMD_PUNCH];
   wire cmd_rep     = wr_cmd & (wmask[punch_pkg::CMD_REP_P]
                              | wmask[punch_pkg::CMD_REP_D]);
   wire cmd_restart = wr_cmd & wmask[punch_pkg::CMD_RESTART];
   wire [9:0] pick_p = wr_pp ? wmask[9:0] : 10'h000;
   wire [9:0] pick_d = wr_pd ? wmask[9:0] : 10'h000;

   // punch requests count only with interlock and not in gangpunch
   wire accept_punch = cmd_punch & ctrl.interlock
                     & ~ctrl.gangpunch;

   // cycle phase decode
   wire in_pre    = (state == punch_pkg::ST_PRE);
   wire in_digit  = (state == punch_pkg::ST_DIGIT);
   wire in_end    = (state == punch_pkg::ST_END);
   wire in_halt   = (state == punch_pkg::ST_HALT);
   wire sub_done  = (sub == punch_pkg::DIGIT_LAST);
   wire slot_done = sub_done & (slot == punch_pkg::SLOT_LAST);
   wire check_err = dp_err | bc_err;
   wire offset_on = ctrl.offset_present & ctrl.offset_enable;
   wire halt_now  = in_end & ((check_err & ctrl.check_error_halt
                    & ~offset_on) | out_err);
   wire good_end  = in_end & ~halt_now;
   wire restart   = in_halt & cmd_restart;
   wire start_cyc = ctrl.gangpunch | punch_req | rep_pend;

   // next state of the punch cycle
   always_comb begin
      next_state = state;
      case (state)
         punch_pkg::ST_IDLE: begin
            if (start_cyc) begin
               next_state = punch_pkg::ST_PRE;
            end
         end
         punch_pkg::ST_PRE: begin
            next_state = punch_pkg::ST_DIGIT;
         end
         punch_pkg::ST_DIGIT: begin
            if (slot_done) begin
               next_state = punch_pkg::ST_END;
            end
         end
         punch_pkg::ST_END: begin
            if (halt_now) begin
               next_state = punch_pkg::ST_HALT;
            end else begin
               next_state = punch_pkg::ST_IDLE;
            end
         end
         punch_pkg::ST_HALT: begin
            if (cmd_restart) begin
               next_state = punch_pkg::ST_PRE;           // run-in
            end
         end
         default: begin
            next_state = punch_pkg::ST_IDLE;
         end
      endcase
   end

   // state and digit-time counters
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state <= punch_pkg::ST_IDLE;
         sub   <= 8'h00;
         slot  <= 4'h0;
      end else begin
         state <= next_state;
         sub   <= (in_digit & ~sub_done) ? sub + 8'h01 : 8'h00;
         if (!in_digit) begin
            slot <= 4'h0;
         end else if (sub_done & ~slot_done) begin
            slot <= slot + 4'h1;
         end
      end
   end

   // punch request waits for the next cycle start
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         punch_req <= 1'b0;
      end else begin
         punch_req <= accept_punch | (punch_req & ~in_pre);
      end
   end

   // repeat: request taken at a good end, kept over a halt
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rep_req  <= 1'b0;
         rep_pend <= 1'b0;
      end else begin
         rep_req  <= cmd_rep | (rep_req & ~good_end);
         if (good_end) begin
            rep_pend <= rep_req;
         end else if (in_pre) begin
            rep_pend <= 1'b0;
         end
      end
   end

   // hole counting per checked column
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         hole_cnt   <= 2'h0;
         first_seen <= 1'b0;
      end else if (brush.col_start) begin
         hole_cnt   <= 2'h0;
         first_seen <= 1'b0;
      end else if (brush.hole) begin
         hole_cnt   <= (hole_cnt == 2'h2) ? hole_cnt : hole_cnt + 2'h1;
         first_seen <= 1'b1;
      end
   end

   wire col_chk   = brush.col_end & brush.checked;
   wire bc_hit    = col_chk & (hole_cnt == 2'h0)
                  & ~ctrl.blank_check_disable;
   wire dp_hit    = col_chk & (hole_cnt == 2'h2) & ~brush.blank_only;
   wire first_hit = brush.hole & brush.checked & brush.blank_only
                  & ~first_seen & ~brush.col_start;

   // error flags: a new error wins over the restart clear
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         dp_err  <= 1'b0;
         bc_err  <= 1'b0;
         out_err <= 1'b0;
      end else begin
         dp_err  <= dp_hit | (dp_err & ~restart & ~good_end);
         bc_err  <= bc_hit | (bc_err & ~restart & ~good_end);
         out_err <= output_error | (out_err & ~restart);
      end
   end

   // pilot selectors, two groups of five
   logic [9:0] d_in;
   genvar i;
   generate
      for (i = 0; i < punch_pkg::NUM_SEL; i++) begin : g_sel
         if (i == 0) begin : g_first
            assign d_in[i] = pick_d[i]
               | (chain[punch_pkg::CHAIN_REP + i] & repeat_out);
         end else begin : g_rest
            assign d_in[i] = pick_d[i]
               | (chain[i-1] & couple_out[i-1])
               | (chain[punch_pkg::CHAIN_REP + i] & repeat_out);
         end
         pilot_selector u_sel (
            .aclk    (aclk),
            .aresetn (aresetn),
            .pick_p  (pick_p[i]),
            .pick_d  (d_in[i]),
            .p_clear (in_end),
            .d_adv   (good_end),
            .pre     (in_pre),
            .xfer    (selector_xfer[i]),
            .couple  (couple_out[i])
         );
      end
   endgenerate

   // status outputs, all registered
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         machine_halt    <= 1'b0;
         check_light     <= 1'b0;
         card_offset     <= 1'b0;
         punching        <= 1'b0;
         digit_slot      <= 4'h0;
         half_after_zero <= 1'b0;
         repeat_out      <= 1'b0;
         combined_entry  <= 1'b0;
      end else begin
         machine_halt    <= (next_state == punch_pkg::ST_HALT);
         check_light     <= (halt_now & check_err)
                          | (check_light & ~restart);
         card_offset     <= in_end & check_err & offset_on;
         punching        <= (next_state == punch_pkg::ST_DIGIT);
         digit_slot      <= slot;
         half_after_zero <= in_digit & (slot == punch_pkg::SLOT_HALF)
                          & (sub == 8'h00);
         repeat_out      <= in_pre & rep_pend;
         combined_entry  <= first_hit;
      end
   end

   // register writes
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl  <= punch_pkg::CTRL_RESET;
         chain <= punch_pkg::CHAIN_RESET;
      end else begin
         if (wr_ctrl) begin
            ctrl <= (ctrl & ~lane) | wmask;
         end
         if (wr_chn) begin
            chain <= (chain & ~lane) | wmask;
         end
      end
   end

   // write handshake and response
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready <= 1'b0;
         wready  <= 1'b0;
         bvalid  <= 1'b0;
         bresp   <= punch_pkg::RESP_OKAY;
      end else begin
         awready <= wr_go;
         wready  <= wr_go;
         if (wr_go) begin
            bvalid <= 1'b1;
            bresp  <= wr_ok ? punch_pkg::RESP_OKAY
                            : punch_pkg::RESP_SLVERR;
         end else if (bready) begin
            bvalid <= 1'b0;
         end
      end
   end

   // read decode
   wire rd_go = arvalid & ~arready & ~rvalid;
   // bits 5:4 spare so the slot stays in the low nibble
   wire [31:0] status = {14'h0000, state, rep_req, rep_pend, out_err,
                         bc_err, dp_err, punch_req, check_light, 2'h0,
                         slot};
   wire [31:0] sel_word = {12'h000, couple_out, selector_xfer};
   wire rd_ctrl = (araddr == punch_pkg::ADDR_CTRL);
   wire rd_chn  = (araddr == punch_pkg::ADDR_CHAIN);
   wire rd_sts  = (araddr == punch_pkg::ADDR_STATUS);
   wire rd_sel  = (araddr == punch_pkg::ADDR_SEL);
   wire rd_wo   = (araddr == punch_pkg::ADDR_CMD)
                | (araddr == punch_pkg::ADDR_PICK_P)
                | (araddr == punch_pkg::ADDR_PICK_D);
   wire rd_ok   = rd_ctrl | rd_chn | rd_sts | rd_sel | rd_wo;
   wire [31:0] rd_word = rd_ctrl ? 32'(ctrl)
                       : rd_chn  ? chain
                       : rd_sts  ? status
                       : rd_sel  ? sel_word
                       : 32'h0000_0000;

   // read handshake, data held until taken
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready <= 1'b0;
         rvalid  <= 1'b0;
         rdata   <= 32'h0000_0000;
         rresp   <= punch_pkg::RESP_OKAY;
      end else begin
         arready <= rd_go;
         if (rd_go) begin
            rvalid <= 1'b1;
            rdata  <= rd_word;
            rresp  <= rd_ok ? punch_pkg::RESP_OKAY
                            : punch_pkg::RESP_SLVERR;
         end else if (rready) begin
            rvalid <= 1'b0;
         end
      end
   end
endmodule

/* shared/punch_pkg.sv */
// constants, field layouts and carrier types for the punch cycle control
// assumes a 125 MHz aclk and an AXI4-Lite master with 32-bit data
// Functional notes
// - blank-only column with multi-holes allowed: first hole exits combined entry
// - check-error halt enabled: double punch or blank column stops the machine
// - offset stacking present and enabled: error card offset instead of halt
// - gangpunch set: punch detached from processor, runs standalone
// - one repeat impulse punches exactly one extra card from same data
// - repeat output pulses just before punching of the second card
// - repeat again on successive cycles for more cards; requester counts
// - pending repeat survives the error restart procedure
// - half-after-zero impulse between zero and one digit times
// - two groups of five two-way pilot selectors
// - program-exit pickup transfers at once, holds to end of punch cycle
// - run-in repunches last card; exit-picked selectors are normal by then
// - delay pickup transfers next cycle for exactly one cycle
// - delay-picked selector state kept across an output error
// - couple pulses before punching: same card for exit, next for delay
// - couple into another delay pickup chains one further cycle
// - check halt lights the check indicator
// - co-selector style pickup transfers at once, holds for the cycle
package punch_pkg;
   localparam logic [7:0] ADDR_CTRL   = 8'h00;
   localparam logic [7:0] ADDR_CMD    = 8'h04;
   localparam logic [7:0] ADDR_PICK_P = 8'h08;
   localparam logic [7:0] ADDR_PICK_D = 8'h0C;
   localparam logic [7:0] ADDR_CHAIN  = 8'h10;
   localparam logic [7:0] ADDR_STATUS = 8'h14;
   localparam logic [7:0] ADDR_SEL    = 8'h18;

   localparam int CMD_PUNCH   = 0;
   localparam int CMD_REP_P   = 1;
   localparam int CMD_REP_D   = 2;
   localparam int CMD_RESTART = 3;

   localparam int NUM_GROUPS = 2;
   localparam int GROUP_SIZE = 5;
   localparam int NUM_SEL    = NUM_GROUPS * GROUP_SIZE;
   localparam int CHAIN_REP  = 10;   // chain bits 10..19: repeat out -> delay

   // digit slots 12,11,0,0.5,1..9
   localparam logic [3:0] SLOT_LAST = 4'hC;
   localparam logic [3:0] SLOT_HALF = 4'h3;
   localparam int DIGIT_NS   = 80;
   localparam int CLK_NS     = 8;
   localparam int DIGIT_CLKS = (DIGIT_NS + CLK_NS - 1) / CLK_NS;
   localparam logic [7:0] DIGIT_LAST = 8'(DIGIT_CLKS - 1);

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic [25:0] unused;
      logic        offset_present;
      logic        gangpunch;
      logic        interlock;
      logic        offset_enable;
      logic        blank_check_disable;
      logic        check_error_halt;
   } ctrl_t;
   localparam logic [31:0] CTRL_RESET  = 32'h0000_0000;
   localparam logic [31:0] CHAIN_RESET = 32'h0000_0000;

   // read-back brush events for one column
   typedef struct packed {
      logic col_start;
      logic hole;
      logic col_end;
      logic checked;
      logic blank_only;
   } brush_t;

   typedef enum logic [4:0] {
      ST_IDLE  = 5'h01,
      ST_PRE   = 5'h02,
      ST_DIGIT = 5'h04,
      ST_END   = 5'h08,
      ST_HALT  = 5'h10
   } cyc_state_t;
endpackage

/* hdl/pilot_selector.sv */
// one two-way pilot selector with exit and delay pickups
// assumes pulses from the cycle controller in the aclk domain
`timescale 1ns/1ps
module pilot_selector (
   input  wire logic aclk,     // system clock
   input  wire logic aresetn,  // sync reset, active low
   input  wire logic pick_p,   // program-exit pickup pulse
   input  wire logic pick_d,   // delay pickup pulse
   input  wire logic p_clear,  // end of every punch cycle
   input  wire logic d_adv,    // end of a cycle that is not halted
   input  wire logic pre,      // just before punching time
   output logic      xfer,     // selector transferred
   output logic      couple    // couple exit pulse
);
   logic p_hold;
   logic d_arm;
   logic d_act;
   wire  next_xfer = pick_p | p_hold | d_act;

   // exit pickup: at once, until the cycle ends; set wins over clear
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         p_hold <= 1'b0;
      end else begin
         p_hold <= pick_p | (p_hold & ~p_clear);
      end
   end

   // delay pickup advances only on good cycles, so an error keeps it
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         d_arm <= 1'b0;
         d_act <= 1'b0;
      end else if (d_adv) begin
         d_act <= d_arm | pick_d;
         d_arm <= 1'b0;
      end else begin
         d_arm <= d_arm | pick_d;
      end
   end

   // outputs registered
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         xfer   <= 1'b0;
         couple <= 1'b0;
      end else begin
         xfer   <= next_xfer;
         couple <= pre & (p_hold | pick_p | d_act);
      end
   end
endmodule

/* verif/punch_cycle_checker.sv */
// concurrent checks on the punch cycle control top ports
// assumes one aclk domain and a bind into every punch_cycle_ctrl
`timescale 1ns/1ps
module punch_cycle_checker (
   input  wire logic       aclk,            // system clock
   input  wire logic       aresetn,         // sync reset, low
   input  wire logic       output_error,    // output error pulse
   input  wire logic       machine_halt,    // machine stopped
   input  wire logic       check_light,     // check lamp
   input  wire logic       card_offset,     // offset pulse
   input  wire logic       punching,        // digit times running
   input  wire logic       half_after_zero, // 0.5 impulse
   input  wire logic       repeat_out,      // repeat out pulse
   input  wire logic       combined_entry,  // first hole exit
   input  wire logic [9:0] couple_out       // couple pulses
);
   logic       oe_seen;
   logic [7:0] run_len;
   // an output error stops without the lamp, so the halt-lamp check ends there
   always_ff @(posedge aclk) begin
      if (!aresetn) oe_seen <= 1'h0;
      else if (output_error) oe_seen <= 1'h1;
   end
   // length of the current run of digit times
   always_ff @(posedge aclk) begin
      if (!aresetn || !punching) run_len <= 8'h00;
      else run_len <= run_len + 8'h01;
   end
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence s_lead;
      ##[0:2] punching;
   endsequence
   a_half_inside: assert property (half_after_zero |-> punching)
      else $error("half impulse outside digit times");
   a_cycle_len: assert property ($fell(punching) |-> run_len == 8'h82)
      else $error("digit times not thirteen slots long");
   a_repeat_lead: assert property (repeat_out |-> s_lead)
      else $error("repeat out not just before punching");
   a_couple_lead: assert property ((|couple_out) |-> s_lead)
      else $error("couple not just before punching");
   a_offset_free: assert property (card_offset |=> (!machine_halt) [*3])
      else $error("offset card also halted");
   a_halt_still: assert property (machine_halt |-> !punching)
      else $error("punching while halted");
   a_halt_lamp: assert property (disable iff (!aresetn || oe_seen)
      $rose(machine_halt) |-> ##[0:2] check_light)
      else $error("check halt without lamp");
   a_lamp_held: assert property (check_light && machine_halt
      |=> check_light || !machine_halt)
      else $error("lamp dropped during halt");
   a_entry_pulse: assert property (combined_entry |=> !combined_entry)
      else $error("combined entry longer than a clock");
endmodule

bind punch_cycle_ctrl punch_cycle_checker i_chk (
   .aclk, .aresetn, .output_error, .machine_halt, .check_light,
   .card_offset, .punching, .half_after_zero, .repeat_out,
   .combined_entry, .couple_out
);

/* verif/brush_model.sv */
// read-back brush model: sends one column of events on request
// assumes go is a one-clock pulse on aclk during digit times
`timescale 1ns/1ps
module brush_model (
   input  wire logic         aclk,       // system clock
   input  wire logic         go,         // start one column
   input  wire logic [1:0]   holes,      // holes in the column
   input  wire logic         checked,    // column is checked
   input  wire logic         blank_only, // only blanks checked
   output punch_pkg::brush_t brush       // brush events
);
   logic [1:0] ph  = 2'h0;
   logic [1:0] cnt = 2'h0;
   initial brush = '0;
   // a gap after each hole keeps every hole a separate pulse
   always @(posedge aclk) begin
      brush <= '0;
      if (go) begin
         cnt <= holes;
         ph  <= 2'h1;
      end else if (ph == 2'h1) begin
         brush <= 5'h10;
         ph    <= 2'h2;
      end else if (ph == 2'h2 && cnt != 2'h0) begin
         brush <= {3'h2, checked, blank_only};
         cnt   <= cnt - 2'h1;
         ph    <= 2'h3;
      end else if (ph == 2'h2) begin
         brush <= {3'h1, checked, blank_only};
         ph    <= 2'h0;
      end else if (ph == 2'h3)
         ph <= 2'h2;
   end
endmodule

/* verif/testbench.sv */
// self-checking bench for the punch cycle control over AXI4-Lite
// assumes the checker is bound in and a brush model feeds read-back
`timescale 1ns/1ps
module testbench;
   logic        aclk = 1'h0, aresetn = 1'h0, output_error = 1'h0;
   logic        awvalid = 1'h0, wvalid = 1'h0, arvalid = 1'h0;
   logic        bready = 1'h1, rready = 1'h1, go = 1'h0, pd = 1'h0;
   logic        chk_col = 1'h0, only = 1'h0;
   logic [1:0]  holes = 2'h0, bresp, rresp, resp;
   logic [3:0]  wstrb = 4'hF, digit_slot;
   logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, rdata, rd;
   logic        awready, wready, bvalid, arready, rvalid;
   logic        machine_halt, check_light, card_offset, punching;
   logic        half_after_zero, repeat_out, combined_entry;
   logic [9:0]  selector_xfer, couple_out, xs1, xs2;
   logic [15:0] row;
   punch_pkg::brush_t brush;
   int          fails = 0, checks_done = 0, cnt[7] = '{default:0}, base[7];
   wire [6:0]   ev = {couple_out[1:0], combined_entry, card_offset,
                      repeat_out, half_after_zero, punching & ~pd};
   // ctrl, holes, checked, blank-only, halt, offset, entry, repeat
   localparam logic [15:0] ROWS [4] = '{16'h09A9, 16'h2D24, 16'h0B20,
                                        16'h09B2};

   punch_cycle_ctrl i_dut (
      .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
      .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
      .arready, .rdata, .rresp, .rvalid, .rready, .brush, .output_error,
      .machine_halt, .check_light, .card_offset, .punching, .digit_slot,
      .half_after_zero, .repeat_out, .combined_entry, .selector_xfer,
      .couple_out
   );
   brush_model i_brush (.aclk, .go, .holes, .checked(chk_col),
                        .blank_only(only), .brush);

   always #4 aclk = ~aclk;
   // pulse counters: cycle starts, 0.5, repeat, offset, entry, couples
   always @(posedge aclk) begin
      pd <= punching;
      if (half_after_zero) chk(digit_slot, 32'h3);
      for (int i = 0; i < 7; i++)
         cnt[i] <= cnt[i] + int'(ev[i]);
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] want);
      checks_done++;
      if (seen !== want) begin
         fails++;
         $display("FAIL t=%0t seen=%h exp=%h", $time, seen, want);
      end
   endtask
   // write and read hold every valid until its own ready
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge aclk);
      awaddr  <= a;
      wdata   <= d;
      awvalid <= 1'h1;
      wvalid  <= 1'h1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'h0;
         if (wready) wvalid <= 1'h0;
      end while (!bvalid);
      resp = bresp;
   endtask
   task automatic rdr(input logic [7:0] a);
      @(posedge aclk);
      araddr  <= a;
      arvalid <= 1'h1;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 1'h0;
      end while (!rvalid);
      rd   = rdata;
      resp = rresp;
   endtask
   // follows one punch cycle; samples selectors and may send a column
   task automatic cyc(input logic col, output logic [9:0] xs);
      int k = 0;
      while (!punching && k < 30) begin
         @(posedge aclk);
         k++;
      end
      repeat (5) @(posedge aclk);
      xs = selector_xfer;
      if (col) begin
         go <= 1'h1;
         @(posedge aclk);
         go <= 1'h0;
      end
      while (punching && k < 300) begin
         @(posedge aclk);
         k++;
      end
      repeat (4) @(posedge aclk);
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   initial begin
      repeat (6) @(posedge aclk);
      aresetn <= 1'h1;
      @(posedge aclk);
      chk({machine_halt, check_light, punching, selector_xfer}, 32'h0);
      rdr(punch_pkg::ADDR_CTRL);
      chk(rd, punch_pkg::CTRL_RESET);
      rdr(punch_pkg::ADDR_CHAIN);
      chk(rd, punch_pkg::CHAIN_RESET);
      wr(punch_pkg::ADDR_CTRL, 32'h0000_002F);
      rdr(punch_pkg::ADDR_CTRL);
      chk(rd, 32'h0000_002F);
      rdr(8'h1C);
      chk(rd, 32'h0);
      chk(resp, punch_pkg::RESP_SLVERR);
      wr(punch_pkg::ADDR_STATUS, 32'h1);
      chk(resp, punch_pkg::RESP_SLVERR);
      $display("registers done");
      wr(punch_pkg::ADDR_CTRL, 32'h0);
      base = cnt;
      wr(punch_pkg::ADDR_CMD, 32'h1);
      repeat (20) @(posedge aclk);
      chk(cnt[0] - base[0], 32'h0);
      $display("interlock done");
      // pass 0 picks delay directly, pass 1 reaches it through a couple
      for (int i = 0; i < 2; i++) begin
         wr(punch_pkg::ADDR_CTRL, 32'h8);
         wr(punch_pkg::ADDR_PICK_D, i ? 32'h0 : 32'h2);
         wr(punch_pkg::ADDR_CHAIN, 32'(i));
         wr(punch_pkg::ADDR_PICK_P, 32'h1);
         base = cnt;
         wr(punch_pkg::ADDR_CMD, i ? 32'h5 : 32'h3);
         cyc(1'h0, xs1);
         cyc(1'h0, xs2);
         chk(xs1, 32'h1);
         chk(xs2, 32'h2);
         chk(selector_xfer, 32'h0);
         chk(cnt[0] - base[0], 32'h2);
         chk(cnt[2] - base[2], 32'h1);
         chk(cnt[1] - base[1], 32'h2);
         chk(cnt[5] - base[5], 32'h1);
         chk(cnt[6] - base[6], 32'h1);
      end
      wr(punch_pkg::ADDR_CHAIN, 32'h0);
      $display("repeat and selectors done");
      foreach (ROWS[r]) begin
         row = ROWS[r];
         wr(punch_pkg::ADDR_CTRL, {24'h0, row[15:8]});
         holes   <= row[7:6];
         chk_col <= row[5];
         only    <= row[4];
         base = cnt;
         wr(punch_pkg::ADDR_CMD, {30'h0, row[0], 1'h1});
         cyc(1'h1, xs1);
         chk(machine_halt, row[3]);
         chk(check_light, row[3]);
         chk(cnt[3] - base[3], row[2]);
         chk(cnt[4] - base[4], row[1]);
         if (row[3]) begin
            base = cnt;
            wr(punch_pkg::ADDR_CMD, 32'h8);
            cyc(1'h0, xs1);
            cyc(1'h0, xs1);
            chk(cnt[0] - base[0], 32'h2);
            chk({check_light, machine_halt}, 32'h0);
         end
      end
      $display("hole checks done");
      // output error: stop without lamp, delay pickup survives run-in
      wr(punch_pkg::ADDR_CTRL, 32'h8);
      wr(punch_pkg::ADDR_PICK_D, 32'h4);
      wr(punch_pkg::ADDR_CMD, 32'h1);
      output_error <= 1'h1;
      @(posedge aclk);
      output_error <= 1'h0;
      cyc(1'h0, xs1);
      chk({machine_halt, check_light}, 32'h2);
      wr(punch_pkg::ADDR_CMD, 32'h8);
      cyc(1'h0, xs2);
      chk({xs1, xs2, selector_xfer}, 32'h4);
      $display("output error done");
      wr(punch_pkg::ADDR_CTRL, 32'h10);
      base = cnt;
      repeat (400) @(posedge aclk);
      chk(cnt[0] - base[0] >= 2, 32'h1);
      wr(punch_pkg::ADDR_CTRL, 32'h0);
      cyc(1'h0, xs1);
      $display("gangpunch done");
      test_done();
   end

   // a full run needs a few thousand clocks
   initial begin
      repeat (20000) @(posedge aclk);
      fails++;
      test_done();
   end
endmodule
